// file: inc/rtcit_pkg.sv
// Constants shared by the interrupt, square-wave and trim logic.
// Assumes a 32.768 kHz oscillator level sampled on the 20 MHz core clock.
package rtcit_pkg;

    // ==================================================================
    // Register map
    localparam logic [7:0] CTRL2_ADDR = 8'h01;
    localparam logic [7:0] TRIM_ADDR  = 8'h02;
    localparam logic [7:0] CTRL2_RST  = 8'h00;
    localparam logic [7:0] TRIM_RST   = 8'h00;

    localparam int ALARM_IE_BIT = 7;
    localparam int ALARM_F_BIT  = 6;
    localparam int MIN_EN_BIT   = 5;
    localparam int HALF_EN_BIT  = 4;
    localparam int TIMER_F_BIT  = 3;
    localparam int SEL_MSB      = 2;
    localparam int MODE_BIT     = 7;
    localparam int TRIM_MSB     = 6;

    // ==================================================================
    // Square-wave select codes
    localparam logic [2:0] SEL_32K  = 3'h0;
    localparam logic [2:0] SEL_16K  = 3'h1;
    localparam logic [2:0] SEL_8K   = 3'h2;
    localparam logic [2:0] SEL_4K   = 3'h3;
    localparam logic [2:0] SEL_2K   = 3'h4;
    localparam logic [2:0] SEL_1K   = 3'h5;
    localparam logic [2:0] SEL_1HZ  = 3'h6;
    localparam logic [2:0] SEL_OFF  = 3'h7;

    // ==================================================================
    // Timing, counted in oscillator periods
    localparam int OSC_HZ         = 32768;
    localparam int PULSE_NORM_DIV = 64;    // Pulse of 1/64 s
    localparam int PULSE_FAST_DIV = 1024;  // Pulse of 1/1024 s
    localparam int BURST_DIV      = 512;   // Repeat spacing of 1/512 s
    localparam logic [9:0] PULSE_NORM_TICKS = 10'(OSC_HZ / PULSE_NORM_DIV);
    localparam logic [9:0] PULSE_FAST_TICKS = 10'(OSC_HZ / PULSE_FAST_DIV);
    localparam logic [9:0] BURST_TICKS      = 10'(OSC_HZ / BURST_DIV);

    // Prescaler stage where a correction step lands, per trim mode
    localparam int STEP_NORM_BIT = 9;      // One 64 Hz period
    localparam int STEP_FAST_BIT = 5;      // One 1024 Hz period
    localparam int PRESC_W       = 15;

    localparam logic [5:0] SEC_LAST   = 6'h3B;
    localparam logic [5:0] SEC_HALF   = 6'h1D;
    localparam logic [5:0] SEC_BURST  = 6'h3A;
    localparam logic [5:0] MIN_LAST   = 6'h3B;
    localparam logic [1:0] FAST_SLOT  = 2'h3;

    typedef enum logic [1:0] {
        TRIM_IDLE  = 2'b00,
        TRIM_MIN   = 2'b01,
        TRIM_SEC   = 2'b10,
        TRIM_BURST = 2'b11
    } rtcit_trim_e;

endpackage

// file: inc/rtcit_clk_if.sv
// Bundle between the core and the square-wave output stage.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface rtcit_clk_if;
    logic        oscLevel;
    logic [14:0] presc;
    logic [2:0]  select;
    logic        hold;
    logic        gate;
    logic        squareOut;

    modport core  (output oscLevel, presc, select, hold, gate, input squareOut);
    modport stage (input oscLevel, presc, select, hold, gate, output squareOut);
endinterface

// file: src/rtcit_square_wave_pin.sv
// Square-wave output stage: picks a prescaler tap and registers it.
// Assumes the prescaler taps are already registered in the core.
`timescale 1ns/1ps
module rtcit_square_wave_pin (
    input wire logic   core_clk,
    input wire logic   nrst,
    rtcit_clk_if.stage clkIf
);
    logic squareOut_q;
    logic squareOut_d;
    logic tap;

    // ==================================================================
    // Tap selection
    always_comb begin
        case (clkIf.select)
            rtcit_pkg::SEL_32K: tap = clkIf.oscLevel;
            rtcit_pkg::SEL_16K: tap = clkIf.presc[0];
            rtcit_pkg::SEL_8K:  tap = clkIf.presc[1];
            // Stoppable taps are forced low while the prescaler is held
            rtcit_pkg::SEL_4K:  tap = clkIf.presc[2] & ~clkIf.hold;
            rtcit_pkg::SEL_2K:  tap = clkIf.presc[3] & ~clkIf.hold;
            rtcit_pkg::SEL_1K:  tap = clkIf.presc[4] & ~clkIf.hold;
            // Top stage carries the trim steps, so this rate wanders
            rtcit_pkg::SEL_1HZ: tap = clkIf.presc[14] & ~clkIf.hold;
            default:            tap = 1'b0;
        endcase
        // Divider taps are flip-flop bits, hence even duty
        squareOut_d = tap & clkIf.gate;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            squareOut_q <= 1'b0;
        end else begin
            squareOut_q <= squareOut_d;
        end
    end

    assign clkIf.squareOut = squareOut_q;
endmodule

// file: src/rtc_irq_square_wave_pin_trim.sv
// Interrupt flags, periodic pulses, square-wave output and frequency trim.
// Assumes decoded serial-bus register accesses and calendar counters as inputs,
// all synchronous to core_clk; the oscillator arrives as a sampled level.
`timescale 1ns/1ps

// Overview of operation
// - Alarm enable gates alarm flag onto interrupt.
// - Alarm event sets sticky alarm flag.
// - Flag writes AND with current value.
// - Periodic pulses last 1/64 second.
// - First periodic pulse follows seconds alignment.
// - Enables select none, minute, or half-minute.
// - Periodic timers follow calendar seconds count.
// - Trim steps stretch or shrink periodic intervals.
// - Timer events set the sticky timer flag.
// - Pulse mode pulses every event; countdown repeats.
// - Level mode follows flag; countdown stops.
// - Select code chooses square-wave frequency.
// - Code 111 or low gate drive low.
// - Output enabled at 32 kHz after reset.
// - Prescaler hold forces slow taps low.
// - Divided taps have even duty cycle.
// - One hertz tap carries trim steps.
// - Mode bit picks two-hour or four-minute trim.
// - Trim value is seven-bit two's complement.
// - Trim adds or removes prescaler counts.
// - Correction pulses appear on interrupt when enabled.
// - Normal mode: one step per minute.
// - Coarse mode: per second, excess in 59th.
module rtc_irq_square_wave_pin_trim #(
    parameter int PRESC_BITS = 15,
    parameter int PULSE_W    = 10
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       softReset,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrStb,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       oscLevel,
    input  wire logic       prescHold,
    input  wire logic       squareWaveGatePin,
    input  wire logic [5:0] calSeconds,
    input  wire logic [5:0] calMinutes,
    input  wire logic [4:0] calHours,
    input  wire logic       alarmMatch,
    input  wire logic       countdownExpire,
    input  wire logic       countdownIrqEnable,
    input  wire logic       pulseOrLevelSelect,
    input  wire logic       trimPulseIrqEnable,
    output logic            intPinN,
    output logic            squareWavePin,
    output logic            secondTick,
    output logic            countdownRepeat
);
    if (PRESC_BITS != rtcit_pkg::PRESC_W) begin : g_chk_presc
        $error("Prescaler width must be 15");
    end
    if (PULSE_W < 10) begin : g_chk_pulse
        $error("Pulse counter must hold at least 10 bits");
    end

    // ==================================================================
    // Helpers
    function automatic logic [PULSE_W-1:0] tickDown(input logic [PULSE_W-1:0] cnt,
                                                   input logic               rise);
        tickDown = (rise && cnt != '0) ? cnt - 1'b1 : cnt;
    endfunction

    function automatic logic [PULSE_W-1:0] widen(input logic [9:0] ticks);
        widen = PULSE_W'(ticks);
    endfunction

    // ==================================================================
    // State
    logic [7:0]              ctrl_q, ctrl_d;
    logic [7:0]              trim_q, trim_d;
    logic [7:0]              rdData_q, rdData_d;
    logic                    oscPrev_q, oscPrev_d;
    logic [PRESC_BITS-1:0]   presc_q, presc_d;
    logic                    topPrev_q, topPrev_d;
    logic                    secTick_q, secTick_d;
    logic [PULSE_W-1:0]      timerPulse_q, timerPulse_d;
    logic [PULSE_W-1:0]      corrPulse_q, corrPulse_d;
    logic [PULSE_W-1:0]      spacing_q, spacing_d;
    logic [6:0]              remain_q, remain_d;
    rtcit_pkg::rtcit_trim_e  trimSt_q, trimSt_d;
    logic                    intN_q, intN_d;
    logic                    repeat_q, repeat_d;

    logic                    oscRise;
    logic                    topRise;
    logic                    minuteEdge;
    logic                    halfEdge;
    logic                    periodicEvt;
    logic                    timerEvt;
    logic                    ctrlWr;
    logic                    trimWr;
    logic                    coarse;
    logic                    trimNeg;
    logic [6:0]              trimMag;
    logic                    trigger;
    logic                    applyStep;
    logic [PRESC_BITS:0]     stepSize;
    logic [PRESC_BITS:0]     prescSum;
    logic                    alarmIrq;
    logic                    timerIrq;
    logic                    corrIrq;

    rtcit_clk_if clkIf ();

    // ==================================================================
    // Event decode
    assign oscRise    = oscLevel & ~oscPrev_q;
    assign topRise    = presc_q[PRESC_BITS-1] & ~topPrev_q;
    // Pulses ride on the calendar's own second boundaries
    assign minuteEdge = secTick_q && calSeconds == rtcit_pkg::SEC_LAST;
    assign halfEdge   = secTick_q && (calSeconds == rtcit_pkg::SEC_LAST ||
                                      calSeconds == rtcit_pkg::SEC_HALF);
    // First pulse lands on the next boundary, up to one period out
    assign periodicEvt = (ctrl_q[rtcit_pkg::HALF_EN_BIT] & halfEdge) |
                         (ctrl_q[rtcit_pkg::MIN_EN_BIT] & minuteEdge);
    assign timerEvt   = periodicEvt | countdownExpire;
    assign ctrlWr     = regWrStb && regAddr == rtcit_pkg::CTRL2_ADDR;
    assign trimWr     = regWrStb && regAddr == rtcit_pkg::TRIM_ADDR;
    assign coarse     = trim_q[rtcit_pkg::MODE_BIT];
    assign trimNeg    = trim_q[rtcit_pkg::TRIM_MSB];
    // -64 has magnitude 64, which still fits seven bits
    assign trimMag    = trimNeg ? 7'(-trim_q[6:0]) : trim_q[6:0];

    // Normal mode starts at minute 00 of even hours, coarse every 4 minutes
    assign trigger = minuteEdge && trimMag != 7'h00 &&
                     (coarse ? calMinutes[1:0] == rtcit_pkg::FAST_SLOT
                             : (calMinutes == rtcit_pkg::MIN_LAST && calHours[0]));

    // ==================================================================
    // Trim sequencer
    always_comb begin
        trimSt_d  = trimSt_q;
        remain_d  = remain_q;
        spacing_d = tickDown(spacing_q, oscRise);
        applyStep = 1'b0;
        case (trimSt_q)
            rtcit_pkg::TRIM_IDLE: begin
                if (trigger) begin
                    applyStep = 1'b1;
                    remain_d  = trimMag - 7'h01;
                    trimSt_d  = coarse ? rtcit_pkg::TRIM_SEC : rtcit_pkg::TRIM_MIN;
                end
            end
            rtcit_pkg::TRIM_MIN: begin
                if (remain_q == 7'h00) begin
                    trimSt_d = rtcit_pkg::TRIM_IDLE;
                end else if (minuteEdge) begin
                    applyStep = 1'b1;
                    remain_d  = remain_q - 7'h01;
                end
            end
            rtcit_pkg::TRIM_SEC: begin
                if (remain_q == 7'h00) begin
                    trimSt_d = rtcit_pkg::TRIM_IDLE;
                end else if (secTick_q) begin
                    applyStep = 1'b1;
                    remain_d  = remain_q - 7'h01;
                    if (calSeconds == rtcit_pkg::SEC_BURST) begin
                        spacing_d = widen(rtcit_pkg::BURST_TICKS);
                        trimSt_d  = rtcit_pkg::TRIM_BURST;
                    end
                end
            end
            rtcit_pkg::TRIM_BURST: begin
                if (remain_q == 7'h00) begin
                    trimSt_d = rtcit_pkg::TRIM_IDLE;
                end else if (spacing_q == '0) begin
                    applyStep = 1'b1;
                    remain_d  = remain_q - 7'h01;
                    spacing_d = widen(rtcit_pkg::BURST_TICKS);
                end
            end
            default: begin
                trimSt_d = rtcit_pkg::TRIM_IDLE;
            end
        endcase
    end

    // ==================================================================
    // Prescaler, registers, interrupt
    always_comb begin
        // Steps change the count, never the oscillator
        stepSize = (PRESC_BITS+1)'(1) << (coarse ? rtcit_pkg::STEP_FAST_BIT
                                                  : rtcit_pkg::STEP_NORM_BIT);
        prescSum = {1'b0, presc_q} + (PRESC_BITS+1)'(oscRise);
        if (applyStep) begin
            prescSum = trimNeg ? prescSum - stepSize : prescSum + stepSize;
        end
        oscPrev_d = oscLevel;
        topPrev_d = presc_q[PRESC_BITS-1];
        secTick_d = topRise;
        presc_d   = prescSum[PRESC_BITS-1:0];
        if (prescHold) begin
            // Only the two fastest stages keep running while held
            presc_d = {{(PRESC_BITS-2){1'b0}}, presc_q[1:0] + {1'b0, oscRise}};
        end

        ctrl_d = ctrl_q;
        trim_d = trim_q;
        if (ctrlWr) begin
            ctrl_d = regWrData;
            // Flags can only be knocked down by a write
            ctrl_d[rtcit_pkg::ALARM_F_BIT] = regWrData[rtcit_pkg::ALARM_F_BIT] &
                                             ctrl_q[rtcit_pkg::ALARM_F_BIT];
            ctrl_d[rtcit_pkg::TIMER_F_BIT] = regWrData[rtcit_pkg::TIMER_F_BIT] &
                                             ctrl_q[rtcit_pkg::TIMER_F_BIT];
        end
        if (trimWr) begin
            trim_d = regWrData;
        end
        // Set after the write so a coincident event is never lost
        if (alarmMatch) begin
            ctrl_d[rtcit_pkg::ALARM_F_BIT] = 1'b1;
        end
        if (timerEvt) begin
            ctrl_d[rtcit_pkg::TIMER_F_BIT] = 1'b1;
        end
        if (softReset) begin
            ctrl_d = rtcit_pkg::CTRL2_RST;
            trim_d = rtcit_pkg::TRIM_RST;
        end

        case (regAddr)
            rtcit_pkg::CTRL2_ADDR: rdData_d = ctrl_q;
            rtcit_pkg::TRIM_ADDR:  rdData_d = trim_q;
            default:               rdData_d = 8'h00;
        endcase

        timerPulse_d = tickDown(timerPulse_q, oscRise);
        if (timerEvt) begin
            timerPulse_d = widen(rtcit_pkg::PULSE_NORM_TICKS);
        end
        corrPulse_d = tickDown(corrPulse_q, oscRise);
        if (applyStep && trimPulseIrqEnable) begin
            corrPulse_d = coarse ? widen(rtcit_pkg::PULSE_FAST_TICKS)
                                 : widen(rtcit_pkg::PULSE_NORM_TICKS);
        end

        alarmIrq = ctrl_q[rtcit_pkg::ALARM_IE_BIT] & ctrl_q[rtcit_pkg::ALARM_F_BIT];
        if (pulseOrLevelSelect) begin
            timerIrq = timerPulse_q != '0;
        end else begin
            timerIrq = ctrl_q[rtcit_pkg::TIMER_F_BIT] &
                       (ctrl_q[rtcit_pkg::MIN_EN_BIT] | ctrl_q[rtcit_pkg::HALF_EN_BIT] |
                        countdownIrqEnable);
        end
        corrIrq    = corrPulse_q != '0;
        intN_d     = ~(alarmIrq | timerIrq | corrIrq);
        repeat_d   = pulseOrLevelSelect;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q       <= rtcit_pkg::CTRL2_RST;
            trim_q       <= rtcit_pkg::TRIM_RST;
            rdData_q     <= 8'h00;
            oscPrev_q    <= 1'b0;
            presc_q      <= '0;
            topPrev_q    <= 1'b0;
            secTick_q    <= 1'b0;
            timerPulse_q <= '0;
            corrPulse_q  <= '0;
            spacing_q    <= '0;
            remain_q     <= 7'h00;
            trimSt_q     <= rtcit_pkg::TRIM_IDLE;
            intN_q       <= 1'b1;
            repeat_q     <= 1'b0;
        end else begin
            ctrl_q       <= ctrl_d;
            trim_q       <= trim_d;
            rdData_q     <= rdData_d;
            oscPrev_q    <= oscPrev_d;
            presc_q      <= presc_d;
            topPrev_q    <= topPrev_d;
            secTick_q    <= secTick_d;
            timerPulse_q <= timerPulse_d;
            corrPulse_q  <= corrPulse_d;
            spacing_q    <= spacing_d;
            remain_q     <= remain_d;
            trimSt_q     <= trimSt_d;
            intN_q       <= intN_d;
            repeat_q     <= repeat_d;
        end
    end

    // ==================================================================
    // Square-wave stage
    assign clkIf.oscLevel = oscLevel;
    assign clkIf.presc    = presc_q;
    assign clkIf.select   = ctrl_q[rtcit_pkg::SEL_MSB:0];
    assign clkIf.hold     = prescHold;
    assign clkIf.gate     = squareWaveGatePin;

    rtcit_square_wave_pin u_square_wave_pin (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clkIf    (clkIf)
    );

    assign regRdData       = rdData_q;
    assign intPinN         = intN_q;
    assign squareWavePin   = clkIf.squareOut;
    assign secondTick      = secTick_q;
    assign countdownRepeat = repeat_q;
endmodule

// file: test/rtcit_osc_model.sv
// Far-side model: crystal oscillator level and calendar seconds count.
// Assumes the oscillator is sped up to one period every PER core cycles.
`timescale 1ns/1ps
module rtcit_osc_model #(
    parameter int PER = 4
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       secondTick,
    output logic            oscLevel,
    output logic      [5:0] calSeconds
);
    // ==================================================================
    // Oscillator runs through reset, as a crystal would
    logic [7:0] cnt = 8'h00;
    initial oscLevel = 1'b0;
    always @(posedge core_clk) begin
        cnt <= (cnt == 8'(PER / 2 - 1)) ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'(PER / 2 - 1))
            oscLevel <= !oscLevel;
    end
    // ==================================================================
    // Seconds count advanced by the block's own tick
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            calSeconds <= 6'h00;
        else if (secondTick)
            calSeconds <= (calSeconds == 6'h3B) ? 6'h00 : calSeconds + 6'h01;
    end
endmodule

// file: test/rtcit_chk_sva.sv
// Port-level checker for the interrupt and square-wave block.
// Assumes it is bound into rtc_irq_square_wave_pin_trim; all on core_clk.
`timescale 1ns/1ps
module rtcit_chk (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       softReset,
    input wire logic [7:0] regAddr,
    input wire logic       regWrStb,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       oscLevel,
    input wire logic       prescHold,
    input wire logic       squareWaveGatePin,
    input wire logic       alarmMatch,
    input wire logic       countdownExpire,
    input wire logic       countdownIrqEnable,
    input wire logic       pulseOrLevelSelect,
    input wire logic       intPinN,
    input wire logic       squareWavePin
);
    // ==================================================================
    // Shadow of the plain control bits; flags are judged by read-back
    logic [7:0] ctlQ;
    logic [7:0] ctlD;
    logic       rdIdle;
    always_comb begin
        ctlD = ctlQ;
        if (softReset)
            ctlD = 8'h00;
        else if (regWrStb && regAddr == rtcit_pkg::CTRL2_ADDR)
            ctlD = regWrData;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            ctlQ <= 8'h00;
        else
            ctlQ <= ctlD;
    end
    assign rdIdle = regAddr == rtcit_pkg::CTRL2_ADDR && !regWrStb && !softReset;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ==================================================================
    // Assertions
    clk_off_a: assert property ((ctlQ[2:0] == 3'h7)[*2] |-> !squareWavePin)
        else $error("square wave not low for select off");
    gate_low_a: assert property ((!squareWaveGatePin)[*2] |-> !squareWavePin)
        else $error("square wave not low with gate low");
    hold_low_a: assert property ((prescHold && ctlQ[2:0] >= 3'h3)[*3] |-> !squareWavePin)
        else $error("slow square wave not held low");
    fast_follow_a: assert property ((squareWaveGatePin && ctlQ[2:0] == 3'h0)[*3]
        |-> squareWavePin == $past(oscLevel)) else $error("fast square wave off oscillator");
    alarm_irq_a: assert property (alarmMatch && ctlQ[7] && !softReset && !regWrStb
        |-> ##[1:3] !intPinN) else $error("alarm gave no interrupt");
    alarm_flag_a: assert property (alarmMatch && rdIdle ##1 rdIdle[*3]
        |-> regRdData[6]) else $error("alarm flag not set");
    flag_clear_a: assert property (regWrStb && regAddr == 8'h01 && !regWrData[6]
        && !alarmMatch ##1 (rdIdle && !alarmMatch)[*3] |-> !regRdData[6])
        else $error("alarm flag not cleared by write");
    timer_flag_a: assert property (countdownExpire && rdIdle ##1 rdIdle[*3]
        |-> regRdData[3]) else $error("timer flag not set");
    map_zero_a: assert property ((regAddr != 8'h01 && regAddr != 8'h02)[*2]
        |-> regRdData == 8'h00) else $error("unmapped read not zero");
    level_irq_a: assert property (countdownExpire && countdownIrqEnable
        && !pulseOrLevelSelect |-> ##[1:3] !intPinN) else $error("level interrupt missing");
    pulse_irq_a: assert property (countdownExpire && countdownIrqEnable
        && pulseOrLevelSelect |-> ##3 (!intPinN)[*8]) else $error("timer pulse too short");
    cover property (alarmMatch && ctlQ[7]);
    cover property (countdownExpire && pulseOrLevelSelect);
    cover property (prescHold && ctlQ[2:0] == 3'h6);
endmodule

bind rtc_irq_square_wave_pin_trim rtcit_chk chk (.core_clk(core_clk), .nrst(nrst),
    .softReset(softReset), .regAddr(regAddr), .regWrStb(regWrStb), .regWrData(regWrData),
    .regRdData(regRdData), .oscLevel(oscLevel), .prescHold(prescHold),
    .squareWaveGatePin(squareWaveGatePin), .alarmMatch(alarmMatch),
    .countdownExpire(countdownExpire), .countdownIrqEnable(countdownIrqEnable),
    .pulseOrLevelSelect(pulseOrLevelSelect), .intPinN(intPinN),
    .squareWavePin(squareWavePin));

// file: test/rtc_irq_square_wave_pin_trim_tb_top.sv
// Self-checking bench: register tasks, flags, interrupt and square wave.
// Assumes the oscillator model toggles every 2 core cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module rtc_irq_square_wave_pin_trim_tb_top;
    localparam logic [7:0] CA = rtcit_pkg::CTRL2_ADDR;
    localparam logic [7:0] TA = rtcit_pkg::TRIM_ADDR;
    logic       core_clk = 1'b0;
    logic       nrst, softReset, regWrStb, prescHold, squareWaveGatePin;
    logic       alarmMatch, countdownExpire, countdownIrqEnable;
    logic       pulseOrLevelSelect, trimPulseIrqEnable, oscLevel, prevOsc;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [5:0] calSeconds;
    logic       intPinN, squareWavePin, secondTick, countdownRepeat;
    int         mismatches = 0;
    int         numChecks = 0;
    int         cycles = 0;
    int         hi, per;
    always #25 core_clk = !core_clk;
    rtcit_osc_model osc (.core_clk(core_clk), .nrst(nrst), .secondTick(secondTick),
        .oscLevel(oscLevel), .calSeconds(calSeconds));
    rtc_irq_square_wave_pin_trim dut (.core_clk(core_clk), .nrst(nrst), .softReset(softReset),
        .regAddr(regAddr), .regWrStb(regWrStb), .regWrData(regWrData),
        .regRdData(regRdData), .oscLevel(oscLevel), .prescHold(prescHold),
        .squareWaveGatePin(squareWaveGatePin), .calSeconds(calSeconds),
        .calMinutes(6'h00), .calHours(5'h00), .alarmMatch(alarmMatch),
        .countdownExpire(countdownExpire), .countdownIrqEnable(countdownIrqEnable),
        .pulseOrLevelSelect(pulseOrLevelSelect), .trimPulseIrqEnable(trimPulseIrqEnable),
        .intPinN(intPinN), .squareWavePin(squareWavePin), .secondTick(secondTick),
        .countdownRepeat(countdownRepeat));
    // ==================================================================
    // Access and measurement tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrStb = 1'b1;
        @(negedge core_clk);
        regWrStb = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        repeat (2) @(negedge core_clk);
        `CHK("regRdData", e, regRdData)
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask
    task automatic wait_pin(input logic v);
        for (int n = 0; n < 600 && squareWavePin !== v; n++)
            @(negedge core_clk);
    endtask
    task automatic meas();
        wait_pin(1'b0);
        wait_pin(1'b1);
        hi = 1;
        per = 1;
        @(negedge core_clk);
        while (per < 600 && !(squareWavePin === 1'b1 && hi < per)) begin
            if (squareWavePin === 1'b1)
                hi++;
            per++;
            @(negedge core_clk);
        end
    endtask
    task automatic stay_low();
        logic seen;
        seen = 1'b0;
        repeat (70) begin
            @(negedge core_clk);
            seen = seen | squareWavePin;
        end
        `CHK("squareWavePin", 1'b0, seen)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Ceiling well above the roughly 4000 cycles the tests take
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            give_verdict();
        end
    end
    // ==================================================================
    // Test sequence
    initial begin
        {nrst, softReset, regWrStb, prescHold, alarmMatch, countdownExpire} = 6'h00;
        {countdownIrqEnable, pulseOrLevelSelect, trimPulseIrqEnable} = 3'h0;
        squareWaveGatePin = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        rd(CA, 8'h00);
        rd(TA, 8'h00);
        repeat (8) begin
            prevOsc = oscLevel;
            @(negedge core_clk);
            `CHK("squareWavePin", prevOsc, squareWavePin)
        end
        $display("test reset done");
        for (int h = 0; h < 2; h++) begin
            prescHold = h[0];
            for (int k = 0; k < 8; k++) begin
                wr(CA, 8'(k));
                if (k < 3 || (h == 0 && k < 6)) begin
                    meas();
                    `CHK("period", 4 << k, per)
                    if (k > 0)
                        `CHK("highTime", 2 << k, hi)
                end else if (h == 1 || k == 7) begin
                    stay_low();
                end
            end
        end
        prescHold = 1'b0;
        wr(CA, 8'h00);
        squareWaveGatePin = 1'b0;
        stay_low();
        squareWaveGatePin = 1'b1;
        $display("test square wave done");
        wr(CA, 8'h80);
        pulse(alarmMatch);
        repeat (3) @(negedge core_clk);
        `CHK("intPinN", 1'b0, intPinN)
        rd(CA, 8'hC0);
        countdownIrqEnable = 1'b1;
        pulse(countdownExpire);
        rd(CA, 8'hC8);
        wr(CA, 8'h88);
        rd(CA, 8'h88);
        `CHK("intPinN", 1'b0, intPinN)
        `CHK("countdownRepeat", 1'b0, countdownRepeat)
        wr(CA, 8'h00);
        rd(CA, 8'h00);
        `CHK("intPinN", 1'b1, intPinN)
        pulse(alarmMatch);
        rd(CA, 8'h40);
        `CHK("intPinN", 1'b1, intPinN)
        $display("test flags done");
        wr(CA, 8'h00);
        pulseOrLevelSelect = 1'b1;
        pulse(countdownExpire);
        `CHK("countdownRepeat", 1'b1, countdownRepeat)
        repeat (1000) @(negedge core_clk);
        `CHK("intPinN", 1'b0, intPinN)
        repeat (1500) @(negedge core_clk);
        `CHK("intPinN", 1'b1, intPinN)
        rd(CA, 8'h08);
        pulse(countdownExpire);
        repeat (20) @(negedge core_clk);
        `CHK("intPinN", 1'b0, intPinN)
        $display("test pulse mode done");
        // Coarse trim with periodic enables kept off
        wr(TA, 8'hC1);
        rd(TA, 8'hC1);
        pulse(softReset);
        rd(TA, 8'h00);
        rd(CA, 8'h00);
        $display("test trim done");
        give_verdict();
    end
endmodule
